// ---- verilog/uiop_pkg.sv ----
package uiop_pkg;

   // Register byte offsets on the AXI4-Lite bus, one aligned word each.
   localparam logic [7:0] P4_DATA_OFF  = 8'h04;
   localparam logic [7:0] P4_DIR_OFF   = 8'h0C;
   localparam logic [7:0] P5_DATA_OFF  = 8'h10;
   localparam logic [7:0] P5_DIR_OFF   = 8'h14;
   localparam logic [7:0] P6_DATA_OFF  = 8'h18;
   localparam logic [7:0] P6_DIR_OFF   = 8'h1C;
   localparam logic [7:0] P7_DATA_OFF  = 8'h20;
   localparam logic [7:0] DISP_SEL_OFF = 8'h24;
   localparam logic [7:0] CONV_CTL_OFF = 8'h28;
   // Latch view alias: data offset plus this reads the stored latch.
   localparam logic [7:0] LATCH_VIEW   = 8'h40;

   // Reset values.
   localparam logic [7:0] LATCH_RST    = 8'hFF;
   localparam logic [7:0] DIR_RST      = 8'h00;
   localparam logic [4:0] P7_RST       = 5'h1F;
   localparam logic [3:0] DSEL_RST     = 4'h0;
   localparam logic [4:0] CONV_RST     = 5'h00;

   // Field positions.
   localparam int CONV_DIS_BIT  = 4;
   localparam int DSEL_LSB      = 4;
   localparam int P7_WIDTH      = 5;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Decoded register selection.
   typedef enum logic [3:0] {
      SEL_NONE   = 4'h0,
      SEL_P4     = 4'h1,
      SEL_P4DIR  = 4'h2,
      SEL_P5     = 4'h3,
      SEL_P5DIR  = 4'h4,
      SEL_P6     = 4'h5,
      SEL_P6DIR  = 4'h6,
      SEL_P7     = 4'h7,
      SEL_DSEL   = 4'h8,
      SEL_CONV   = 4'h9
   } uiop_sel_e;

   // Software-visible state of the four ports.
   typedef struct packed {
      logic [7:0] p4_latch;
      logic [7:0] p4_dir;
      logic [7:0] p5_latch;
      logic [7:0] p5_dir;
      logic [7:0] p6_latch;
      logic [7:0] p6_dir;
      logic [4:0] p7_latch;
      logic [3:0] dsel;
      logic [4:0] conv;
   } uiop_regs_s;

endpackage : uiop_pkg

// ---- verilog/uiop_pin_cell.sv ----
module uiop_pin_cell #(
   parameter int W = 8
) (
   input  wire logic         CLK,     // System clock.
   input  wire logic         RST_N,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] latch_d, // Next output latch value.
   input  wire logic [W-1:0] drive_d, // Next drive enable, 1 drives.
   input  wire logic [W-1:0] alt_en,  // Shared function owns the bit.
   input  wire logic [W-1:0] alt_val, // Shared function level.
   output logic      [W-1:0] pin_out, // Registered pin level.
   output logic      [W-1:0] pin_oe_n // Registered enable, low drives.
);

   logic [W-1:0] out_d;
   logic [W-1:0] oe_n_d;

   // Pin follows the latch unless a shared function owns the bit.
   always_comb begin
      out_d  = (alt_en & alt_val) | (~alt_en & latch_d);
      oe_n_d = ~drive_d;
   end

   // Built from next values so the pin moves in the storing cycle.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_out  <= '1;
         pin_oe_n <= '1;
      end else begin
         pin_out  <= out_d;
         pin_oe_n <= oe_n_d;
      end
   end

endmodule : uiop_pin_cell

// ---- verilog/uiop_ports.sv ----
module uiop_ports (
   input  wire logic       CLK,           // System clock, 50 MHz.
   input  wire logic       RST_N,         // Asynchronous reset, active low.
   input  wire logic [7:0] S_AXI_AWADDR,  // Write address.
   input  wire logic       S_AXI_AWVALID, // Write address valid.
   output logic            S_AXI_AWREADY, // Write address ready.
   input  wire logic [31:0] S_AXI_WDATA,  // Write data.
   input  wire logic [3:0] S_AXI_WSTRB,   // Write byte strobes.
   input  wire logic       S_AXI_WVALID,  // Write data valid.
   output logic            S_AXI_WREADY,  // Write data ready.
   output logic [1:0]      S_AXI_BRESP,   // Write response.
   output logic            S_AXI_BVALID,  // Write response valid.
   input  wire logic       S_AXI_BREADY,  // Write response ready.
   input  wire logic [7:0] S_AXI_ARADDR,  // Read address.
   input  wire logic       S_AXI_ARVALID, // Read address valid.
   output logic            S_AXI_ARREADY, // Read address ready.
   output logic [31:0]     S_AXI_RDATA,   // Read data.
   output logic [1:0]      S_AXI_RRESP,   // Read response.
   output logic            S_AXI_RVALID,  // Read data valid.
   input  wire logic       S_AXI_RREADY,  // Read data ready.
   input  wire logic [7:0] P4_IN,         // Port 4 pin levels.
   output logic [7:0]      P4_OUT,        // Port 4 pin drive level.
   output logic [7:0]      P4_OE_N,       // Port 4 enable, low drives.
   input  wire logic [7:0] P4_PWM_EN,     // Port 4 PWM channel active.
   input  wire logic [7:0] P4_PWM,        // Port 4 PWM levels.
   input  wire logic [7:0] P5_IN,         // Port 5 pin levels.
   output logic [7:0]      P5_OUT,        // Port 5 pin drive level.
   output logic [7:0]      P5_OE_N,       // Port 5 enable, low drives.
   input  wire logic [7:0] P5_PWM_EN,     // Port 5 PWM channel active.
   input  wire logic [7:0] P5_PWM,        // Port 5 PWM levels.
   input  wire logic [7:0] P6_IN,         // Port 6 pin levels.
   output logic [7:0]      P6_OUT,        // Port 6 pin drive level.
   output logic [7:0]      P6_OE_N,       // Port 6 enable, low drives.
   input  wire logic [3:0] OVERLAY_RGBY,  // Overlay colours for bits 7:4.
   input  wire logic [4:0] P7_IN,         // Port 7 pin levels.
   output logic [4:0]      P7_OUT,        // Port 7 drive level.
   output logic [4:0]      P7_OE_N,       // Port 7 enable, low drives.
   output logic            ANALOG_DISABLE,// Converter input disable.
   output logic [3:0]      ANALOG_CHANNEL // Converter channel select.
);

   uiop_pkg::uiop_regs_s regs_q, regs_d;

   logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic       wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        an_dis_q, an_dis_d;
   logic [3:0]  an_ch_q, an_ch_d;
   logic        wr_fire;
   logic        rd_fire;
   logic [4:0]  p7_drive;

   // Decodes an address into a register; latch view aliases share it.
   function automatic uiop_pkg::uiop_sel_e decode(input logic [7:0] a);
      logic [7:0] b;
      b = a & ~uiop_pkg::LATCH_VIEW;
      if (b == uiop_pkg::P4_DATA_OFF) decode = uiop_pkg::SEL_P4;
      else if (b == uiop_pkg::P5_DATA_OFF) decode = uiop_pkg::SEL_P5;
      else if (b == uiop_pkg::P6_DATA_OFF) decode = uiop_pkg::SEL_P6;
      else if (b == uiop_pkg::P7_DATA_OFF) decode = uiop_pkg::SEL_P7;
      else if (a == uiop_pkg::P4_DIR_OFF) decode = uiop_pkg::SEL_P4DIR;
      else if (a == uiop_pkg::P5_DIR_OFF) decode = uiop_pkg::SEL_P5DIR;
      else if (a == uiop_pkg::P6_DIR_OFF) decode = uiop_pkg::SEL_P6DIR;
      else if (a == uiop_pkg::DISP_SEL_OFF) decode = uiop_pkg::SEL_DSEL;
      else if (a == uiop_pkg::CONV_CTL_OFF) decode = uiop_pkg::SEL_CONV;
      else decode = uiop_pkg::SEL_NONE;
   endfunction : decode

   // Pin view: input bits show the pin, output bits the latch.
   function automatic logic [7:0] pin_view(input logic [7:0] pin,
                                           input logic [7:0] lat,
                                           input logic [7:0] dir);
      pin_view = (pin & ~dir) | (lat & dir);
   endfunction : pin_view

   assign wr_fire = aw_q && w_q && !bv_q;
   assign rd_fire = S_AXI_ARVALID && !rv_q;

   // Write channel: address and data are held apart until both arrive.
   always_comb begin
      aw_d     = aw_q;
      w_d      = w_q;
      bv_d     = bv_q;
      awaddr_d = awaddr_q;
      wdata_d  = wdata_q;
      wstrb_d  = wstrb_q;
      bresp_d  = bresp_q;
      if (S_AXI_AWVALID && !aw_q) begin
         aw_d     = 1'b1;
         awaddr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q) begin
         w_d     = 1'b1;
         wdata_d = S_AXI_WDATA[7:0];
         wstrb_d = S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
         aw_d    = 1'b0;
         w_d     = 1'b0;
         bv_d    = 1'b1;
         bresp_d = (decode(awaddr_q) == uiop_pkg::SEL_NONE) ?
                   uiop_pkg::RESP_SLVERR : uiop_pkg::RESP_OKAY;
      end else if (bv_q && S_AXI_BREADY) begin
         bv_d = 1'b0;
      end
   end

   // Register file. A whole byte is stored, so a read-modify-write
   // through the pin view copies pin levels into input-bit latches.
   always_comb begin
      regs_d = regs_q;
      if (wr_fire && wstrb_q) begin
         case (decode(awaddr_q))
            uiop_pkg::SEL_P4:    regs_d.p4_latch = wdata_q;
            uiop_pkg::SEL_P5:    regs_d.p5_latch = wdata_q;
            uiop_pkg::SEL_P6:    regs_d.p6_latch = wdata_q;
            uiop_pkg::SEL_P7:
               regs_d.p7_latch = wdata_q[uiop_pkg::P7_WIDTH-1:0];
            uiop_pkg::SEL_P4DIR: regs_d.p4_dir = wdata_q;
            uiop_pkg::SEL_P5DIR: regs_d.p5_dir = wdata_q;
            uiop_pkg::SEL_P6DIR: regs_d.p6_dir = wdata_q;
            uiop_pkg::SEL_DSEL:
               regs_d.dsel = wdata_q[uiop_pkg::DSEL_LSB +: 4];
            uiop_pkg::SEL_CONV:
               regs_d.conv = wdata_q[uiop_pkg::CONV_DIS_BIT:0];
            default: regs_d = regs_q;
         endcase
      end
      an_dis_d = regs_d.conv[uiop_pkg::CONV_DIS_BIT];
      an_ch_d  = regs_d.conv[3:0];
   end

   // Read channel: one word, answered the cycle after the address.
   always_comb begin
      rv_d    = rv_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rd_fire) begin
         rv_d    = 1'b1;
         rresp_d = uiop_pkg::RESP_OKAY;
         rdata_d = '0;
         // Latch view serves read-modify-write, the plain one the pins.
         case (decode(S_AXI_ARADDR))
            uiop_pkg::SEL_P4: rdata_d[7:0] =
               S_AXI_ARADDR[6] ? regs_q.p4_latch :
               pin_view(P4_IN, regs_q.p4_latch, regs_q.p4_dir);
            uiop_pkg::SEL_P5: rdata_d[7:0] =
               S_AXI_ARADDR[6] ? regs_q.p5_latch :
               pin_view(P5_IN, regs_q.p5_latch, regs_q.p5_dir);
            uiop_pkg::SEL_P6: rdata_d[7:0] =
               S_AXI_ARADDR[6] ? regs_q.p6_latch :
               pin_view(P6_IN, regs_q.p6_latch, regs_q.p6_dir);
            // Upper three bits are undefined and read as zero here.
            uiop_pkg::SEL_P7: rdata_d[4:0] =
               S_AXI_ARADDR[6] ? regs_q.p7_latch : P7_IN;
            uiop_pkg::SEL_DSEL:
               rdata_d[uiop_pkg::DSEL_LSB +: 4] = regs_q.dsel;
            uiop_pkg::SEL_CONV:
               rdata_d[uiop_pkg::CONV_DIS_BIT:0] = regs_q.conv;
            // Direction registers are write-only and read as zero.
            uiop_pkg::SEL_P4DIR, uiop_pkg::SEL_P5DIR,
            uiop_pkg::SEL_P6DIR: rdata_d = '0;
            default: rresp_d = uiop_pkg::RESP_SLVERR;
         endcase
      end else if (rv_q && S_AXI_RREADY) begin
         rv_d = 1'b0;
      end
   end

   // State registers with their reset values.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         regs_q.p4_latch <= uiop_pkg::LATCH_RST;
         regs_q.p5_latch <= uiop_pkg::LATCH_RST;
         regs_q.p6_latch <= uiop_pkg::LATCH_RST;
         regs_q.p7_latch <= uiop_pkg::P7_RST;
         regs_q.p4_dir   <= uiop_pkg::DIR_RST;
         regs_q.p5_dir   <= uiop_pkg::DIR_RST;
         regs_q.p6_dir   <= uiop_pkg::DIR_RST;
         regs_q.dsel     <= uiop_pkg::DSEL_RST;
         regs_q.conv     <= uiop_pkg::CONV_RST;
         an_dis_q <= 1'b0;
         an_ch_q  <= 4'h0;
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         bv_q     <= 1'b0;
         rv_q     <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 8'h00;
         wstrb_q  <= 1'b0;
         bresp_q  <= uiop_pkg::RESP_OKAY;
         rresp_q  <= uiop_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else begin
         regs_q   <= regs_d;
         an_dis_q <= an_dis_d;
         an_ch_q  <= an_ch_d;
         aw_q     <= aw_d;
         w_q      <= w_d;
         bv_q     <= bv_d;
         rv_q     <= rv_d;
         awaddr_q <= awaddr_d;
         wdata_q  <= wdata_d;
         wstrb_q  <= wstrb_d;
         bresp_q  <= bresp_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   assign S_AXI_AWREADY  = !aw_q;
   assign S_AXI_WREADY   = !w_q;
   assign S_AXI_BVALID   = bv_q;
   assign S_AXI_BRESP    = bresp_q;
   assign S_AXI_ARREADY  = !rv_q;
   assign S_AXI_RVALID   = rv_q;
   assign S_AXI_RDATA    = rdata_q;
   assign S_AXI_RRESP    = rresp_q;
   assign ANALOG_DISABLE = an_dis_q;
   assign ANALOG_CHANNEL = an_ch_q;

   // PWM takes a pin only while its latch holds 1, so a cleared latch
   // keeps the pin low rather than passing the channel through.
   uiop_pin_cell #(.W(8)) u_p4 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .latch_d  (regs_d.p4_latch),
      .drive_d  (regs_d.p4_dir),
      .alt_en   (P4_PWM_EN & regs_d.p4_latch),
      .alt_val  (P4_PWM),
      .pin_out  (P4_OUT),
      .pin_oe_n (P4_OE_N)
   );

   uiop_pin_cell #(.W(8)) u_p5 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .latch_d  (regs_d.p5_latch),
      .drive_d  (regs_d.p5_dir),
      .alt_en   (P5_PWM_EN & regs_d.p5_latch),
      .alt_val  (P5_PWM),
      .pin_out  (P5_OUT),
      .pin_oe_n (P5_OE_N)
   );

   // Overlay colours need both select and output direction.
   uiop_pin_cell #(.W(8)) u_p6 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .latch_d  (regs_d.p6_latch),
      .drive_d  (regs_d.p6_dir),
      .alt_en   ({regs_d.dsel, 4'h0}),
      .alt_val  ({OVERLAY_RGBY, 4'h0}),
      .pin_out  (P6_OUT),
      .pin_oe_n (P6_OE_N)
   );

   // Port 7 has no direction bits: it pulls low only for a 0 latch.
   assign p7_drive = ~regs_d.p7_latch;

   uiop_pin_cell #(.W(5)) u_p7 (
      .CLK      (CLK),
      .RST_N    (RST_N),
      .latch_d  (regs_d.p7_latch),
      .drive_d  (p7_drive),
      .alt_en   (5'h00),
      .alt_val  (5'h00),
      .pin_out  (P7_OUT),
      .pin_oe_n (P7_OE_N)
   );

endmodule : uiop_ports

// ---- tb/uiop_ports_props.sv ----
module uiop_ports_props (
   input wire logic        CLK,            // Clock.
   input wire logic        RST_N,          // Reset, active low.
   input wire logic        S_AXI_AWVALID,  // Write address valid.
   input wire logic        S_AXI_AWREADY,  // Write address ready.
   input wire logic        S_AXI_WVALID,   // Write data valid.
   input wire logic        S_AXI_WREADY,   // Write data ready.
   input wire logic        S_AXI_BVALID,   // Write response valid.
   input wire logic [7:0]  S_AXI_ARADDR,   // Read address.
   input wire logic        S_AXI_ARVALID,  // Read address valid.
   input wire logic        S_AXI_ARREADY,  // Read address ready.
   input wire logic        S_AXI_RVALID,   // Read data valid.
   input wire logic [31:0] S_AXI_RDATA,    // Read data.
   input wire logic [7:0]  P4_OUT,         // Port 4 level.
   input wire logic [7:0]  P4_OE_N,        // Port 4 enable.
   input wire logic [7:0]  P5_OUT,         // Port 5 level.
   input wire logic [7:0]  P5_PWM_EN,      // Port 5 PWM active.
   input wire logic [7:0]  P6_OE_N,        // Port 6 enable.
   input wire logic        ANALOG_DISABLE, // Converter disable.
   input wire logic [3:0]  ANALOG_CHANNEL  // Converter channel.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ar_q; // Address of the read in flight.

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // The read answer is judged by its target, so keep the address.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) ar_q <= 8'h00;
      else if (S_AXI_ARVALID && S_AXI_ARREADY) ar_q <= S_AXI_ARADDR;
   end

   // Enables, control and pin levels without PWM or overlay move only at the edge where a write lands.
   property p_rst_pins; $rose(RST_N) |-> P4_OUT == 8'hFF && P4_OE_N == 8'hFF;
   endproperty
   property p_rst_conv; $rose(RST_N) |-> !ANALOG_DISABLE && !ANALOG_CHANNEL;
   endproperty
   property p_oe4; $changed(P4_OE_N) |-> $rose(S_AXI_BVALID); endproperty
   property p_oe6; $changed(P6_OE_N) |-> $rose(S_AXI_BVALID); endproperty
   property p_out5; $changed(P5_OUT) && $past(P5_PWM_EN) == 8'h00
      |-> $rose(S_AXI_BVALID); endproperty
   property p_conv; $changed({ANALOG_DISABLE, ANALOG_CHANNEL})
      |-> $rose(S_AXI_BVALID); endproperty
   property p_wr_lat; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##2 S_AXI_BVALID; endproperty
   property p_p7rd; S_AXI_RVALID && ar_q == uiop_pkg::P7_DATA_OFF
      |-> S_AXI_RDATA[31:5] == 27'h0; endproperty

   a_rst_pins: assert property (p_rst_pins) else $error("pin reset");
   a_rst_conv: assert property (p_rst_conv) else $error("conv reset");
   a_oe4: assert property (p_oe4) else $error("p4 enable moved");
   a_oe6: assert property (p_oe6) else $error("p6 enable moved");
   a_out5: assert property (p_out5) else $error("p5 level moved");
   a_conv: assert property (p_conv) else $error("conv moved");
   a_wr_lat: assert property (p_wr_lat) else $error("write late");
   a_p7rd: assert property (p_p7rd) else $error("p7 high bits");

   c_wr: cover property ($rose(S_AXI_BVALID));
   c_p7: cover property (S_AXI_RVALID && ar_q == uiop_pkg::P7_DATA_OFF);
   c_drv: cover property (P4_OE_N == 8'h00);
endmodule : uiop_ports_props

bind uiop_ports uiop_ports_props u_props (.CLK(CLK), .RST_N(RST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
   .P4_OUT(P4_OUT), .P4_OE_N(P4_OE_N), .P5_OUT(P5_OUT),
   .P5_PWM_EN(P5_PWM_EN), .P6_OE_N(P6_OE_N),
   .ANALOG_DISABLE(ANALOG_DISABLE), .ANALOG_CHANNEL(ANALOG_CHANNEL));

// ---- tb/uiop_pin_model.sv ----
module uiop_pin_model (
   input  wire logic [7:0] p4_out,  // Port 4 level.
   input  wire logic [7:0] p4_oe_n, // Port 4 enable.
   input  wire logic [7:0] p5_out,  // Port 5 level.
   input  wire logic [7:0] p5_oe_n, // Port 5 enable.
   input  wire logic [7:0] p6_out,  // Port 6 level.
   input  wire logic [7:0] p6_oe_n, // Port 6 enable.
   input  wire logic [4:0] p7_out,  // Port 7 level.
   input  wire logic [4:0] p7_oe_n, // Port 7 enable.
   input  wire logic [7:0] ext4,    // Outside level on port 4.
   input  wire logic [7:0] ext5,    // Outside level on port 5.
   input  wire logic [7:0] ext6,    // Outside level on port 6.
   input  wire logic [4:0] ext7,    // Outside level on port 7.
   output logic      [7:0] p4_in,   // Wire level, port 4.
   output logic      [7:0] p5_in,   // Wire level, port 5.
   output logic      [7:0] p6_in,   // Wire level, port 6.
   output logic      [4:0] p7_in    // Wire level, port 7.
);
   timeunit 1ns;
   timeprecision 1ps;
   // A driven pin shows the port; a released one the outside circuit.
   // The outside always drives, so no released wire floats.
   assign p4_in = (p4_out & ~p4_oe_n) | (ext4 & p4_oe_n);
   assign p5_in = (p5_out & ~p5_oe_n) | (ext5 & p5_oe_n);
   assign p6_in = (p6_out & ~p6_oe_n) | (ext6 & p6_oe_n);
   assign p7_in = (p7_out & ~p7_oe_n) | (ext7 & p7_oe_n);
endmodule : uiop_pin_model

// ---- tb/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, awv, wv, brdy, arv, rrdy, awr, wr_r, bv;
   logic        arr, rv, adis;
   logic [7:0]  awa, ara, pe4, pw4, pw5, x4, x5, x6, lat, dir;
   logic [7:0]  p4o, p4e, p5o, p5e, p6o, p6e, p4i, p5i, p6i;
   logic [4:0]  x7, p7o, p7e, p7i;
   logic [3:0]  ovl, ach;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] wd, rdat, got;
   logic [31:0] seed = 32'h00000036;
   logic [23:0] v;
   logic [7:0]  doff [3] = '{8'h04, 8'h10, 8'h18};
   logic [7:0]  roff [3] = '{8'h0C, 8'h14, 8'h1C};
   int          error_cnt, comparisons, i, k;

   uiop_ports uut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rrdy), .P4_IN(p4i), .P4_OUT(p4o), .P4_OE_N(p4e),
      .P4_PWM_EN(pe4), .P4_PWM(pw4), .P5_IN(p5i), .P5_OUT(p5o),
      .P5_OE_N(p5e), .P5_PWM_EN(8'h00), .P5_PWM(pw5), .P6_IN(p6i),
      .P6_OUT(p6o), .P6_OE_N(p6e), .OVERLAY_RGBY(ovl), .P7_IN(p7i),
      .P7_OUT(p7o), .P7_OE_N(p7e), .ANALOG_DISABLE(adis),
      .ANALOG_CHANNEL(ach));
   uiop_pin_model u_pins (.p4_out(p4o), .p4_oe_n(p4e), .p5_out(p5o),
      .p5_oe_n(p5e), .p6_out(p6o), .p6_oe_n(p6e), .p7_out(p7o),
      .p7_oe_n(p7e), .ext4(x4), .ext5(x5), .ext6(x6), .ext7(x7),
      .p4_in(p4i), .p5_in(p5i), .p6_in(p6i), .p7_in(p7i));

   // Xorshift keeps the random run repeatable.
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   // Pin view of port i: level, enable, outside level.
   function automatic logic [23:0] pv(input int i);
      case (i)
         0: return {p4o, p4e, x4};
         1: return {p5o, p5e, x5};
         default: return {p6o, p6e, x6};
      endcase
   endfunction : pv

   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Address and data go out together; each drops once taken.
   // Only the watchdog ends a wait, so a slow answer is never cut short.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awa <= a;
      awv <= 1'b1;
      wd <= {24'h000000, d};
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_r === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      brdy <= 1'b0;
      resp = bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1);
      rrdy <= 1'b0;
      got = rdat;
      resp = rresp;
   endtask : rd

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // A hung handshake must still end the run with a verdict.
   initial begin
      #(20 * 20000);
      error_cnt++;
      print_verdict();
   end

   initial begin
      {rst_n, awv, wv, brdy, arv, rrdy} = 6'h00;
      {awa, ara, pe4, pw4, pw5, wd} = 72'h0;
      {x4, x5, x6, x7, ovl} = 33'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({p4o & p5o & p6o, p4e & p5e & p6e, p7o, p7e, adis, ach},
          {uiop_pkg::LATCH_RST, 8'hFF, uiop_pkg::P7_RST, 5'h1F, 5'h00});
      for (i = 0; i < 3; i++) begin
         rd(doff[i] | uiop_pkg::LATCH_VIEW);
         chk(got, 32'hFF);
         rd(doff[i]);
         chk(got, 32'h0);
      end
      $display("reset test done");
      for (k = 0; k < 30; k++) begin
         i = k % 3;
         lat = rnd();
         dir = rnd();
         x4 <= rnd();
         x5 <= rnd();
         x6 <= rnd();
         wr(doff[i], lat);
         wr(roff[i], dir);
         rd(doff[i] | uiop_pkg::LATCH_VIEW);
         chk(got, {24'h0, lat});
         rd(doff[i]);
         v = pv(i);
         chk(got, {24'h0, (lat & dir) | (v[7:0] & ~dir)});
         chk({v[23:16] & dir, v[15:8]}, {lat & dir, ~dir});
      end
      // Mixed port: a byte read from the pins and written back lands
      // the pin levels in the latches of the input bits.
      wr(doff[1], 8'h0F);
      wr(roff[1], 8'h33);
      rd(doff[1]);
      lat = (8'h0F & 8'h33) | (x5 & 8'hCC);
      chk(got, {24'h0, lat});
      wr(doff[1], got[7:0] ^ 8'h01);
      rd(doff[1] | uiop_pkg::LATCH_VIEW);
      chk(got, {24'h0, lat ^ 8'h01});
      $display("port test done");
      pw4 <= rnd();
      pe4 <= 8'hFF;
      wr(doff[0], 8'hFF);
      wr(roff[0], 8'hFF);
      repeat (3) @(posedge clk);
      chk(p4o, pw4);
      wr(doff[0], 8'h0F);
      repeat (3) @(posedge clk);
      chk(p4o, pw4 & 8'h0F);
      lat = rnd();
      ovl <= lat[3:0];
      wr(doff[2], 8'hFF);
      wr(roff[2], 8'h0F);
      wr(uiop_pkg::DISP_SEL_OFF, 8'hF0);
      chk(p6e[7:4], 4'hF);
      wr(roff[2], 8'hFF);
      repeat (3) @(posedge clk);
      chk(p6o, {ovl, 4'hF});
      $display("shared function test done");
      wr(uiop_pkg::P7_DATA_OFF, 8'hFF);
      lat = rnd();
      x7 <= lat[4:0];
      rd(uiop_pkg::P7_DATA_OFF);
      chk(got, {27'h0, x7});
      wr(uiop_pkg::P7_DATA_OFF, 8'hEA);
      rd(uiop_pkg::P7_DATA_OFF);
      chk({p7e, got}, {5'h0A, 27'h0, x7 & 5'h0A});
      for (k = 0; k < 4; k++) begin
         lat = rnd();
         wr(uiop_pkg::CONV_CTL_OFF, lat);
         chk({adis, ach}, lat[4:0]);
      end
      wr(8'h3C, 8'h55);
      chk(resp, uiop_pkg::RESP_SLVERR);
      rd(8'h3C);
      chk({resp, got}, {uiop_pkg::RESP_SLVERR, 32'h0});
      $display("port 7 and control test done");
      print_verdict();
   end
endmodule : testbench
